/* File: move_and_pointer_load_ops_test.sv */
`timescale 1ns/1ps
`default_nettype none
module move_and_pointer_load_ops_test
  import mpl_pkg::*;
;
  logic                      mclk_i;
  logic                      resetn_i;
  logic [WORD_W-1:0]         instr_i;
  logic                      ext_set_en_i;
  logic [1:0]                phase_o;
  logic                      second_word_o;
  logic [ADDR_W-1:0]         dmem_addr_o;
  logic                      dmem_rd_o;
  logic                      dmem_wr_o;
  logic [DATA_W-1:0]         dmem_wdata_o;
  logic [DATA_W-1:0]         dmem_rdata_i;
  logic [DATA_W-1:0]         acc_o;
  logic [DATA_W-1:0]         bank_selector_o;
  logic [NUM_PTR*ADDR_W-1:0] data_pointer_pair_o;
  logic                      flag_n_o;
  logic                      flag_z_o;
  int                        fail_count;
  int                        checks_done;
  int                        cycles;
  mpl_move_exec i_mpl_move_exec (.mclk_i, .resetn_i, .instr_i, .phase_o, .second_word_o,
    .ext_set_en_i, .dmem_addr_o, .dmem_rd_o, .dmem_wr_o, .dmem_wdata_o, .dmem_rdata_i,
    .acc_o, .bank_selector_o, .data_pointer_pair_o, .flag_n_o, .flag_z_o);
  mpl_dmem_model i_mpl_dmem_model (.mclk_i, .addr_i(dmem_addr_o), .rd_i(dmem_rd_o),
    .wr_i(dmem_wr_o), .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One instruction cycle, returns with results settled
  task automatic issue(input logic [15:0] w);
    instr_i <= w;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_literals;
    issue(16'h0e5a);
    check(acc_o, 8'h5a);
    issue(16'h01f7);
    check(bank_selector_o, 8'h07);
    issue(16'h0e00);
    check({acc_o, flag_n_o, flag_z_o}, 10'h000);
  endtask
  task automatic t_pointers;
    logic [11:0] k;
    logic [35:0] e;
    for (int p = 0; p < 3; p++) begin
      k = {4'(p + 3), 8'hab ^ 8'(p)};
      issue({PTR_LOAD_PFX, 2'(p), k[11:8]});
      check(data_pointer_pair_o[12*p+8 +: 4], k[11:8]);
      check(second_word_o, 1'b1);
      issue({8'hf0, k[7:0]});
      check(data_pointer_pair_o[12*p +: 12], k);
      check(second_word_o, 1'b0);
      e[12*p +: 12] = k;
    end
    issue({PTR_LOAD_PFX, 2'h3, 4'h9});
    check(data_pointer_pair_o, e);
    check({flag_n_o, flag_z_o}, 2'b00);
  endtask
  task automatic fcopy(input logic [15:0] w, input logic [11:0] a, input logic [7:0] v);
    logic [7:0] acc_was;
    acc_was = acc_o;
    i_mpl_dmem_model.mem[a] = v;
    instr_i <= w;
    repeat (2) @(posedge mclk_i);
    #1;
    i_mpl_dmem_model.mem[a] = ~v;
    repeat (2) @(posedge mclk_i);
    #1;
    check(dmem_addr_o, a);
    check(acc_o, w[9] ? acc_was : v);
    check(i_mpl_dmem_model.mem[a], w[9] ? v : 8'(~v));
    check({flag_n_o, flag_z_o}, {v[7], v == 8'h00});
  endtask
  task automatic t_file_copy;
    fcopy(16'h5012, 12'h012, 8'h80);
    fcopy(16'h50a5, 12'hfa5, 8'h00);
    fcopy(16'h5134, 12'h734, 8'h5c);
    fcopy(16'h51ff, 12'h7ff, 8'h11);
    fcopy(16'h5260, 12'hf60, 8'h3c);
    ext_set_en_i <= 1'b1;
    fcopy(16'h505f, 12'h608, 8'h22);
    fcopy(16'h5060, 12'hf60, 8'h44);
    fcopy(16'h5305, 12'h705, 8'h9e);
    ext_set_en_i <= 1'b0;
  endtask
  task automatic xcopy(input logic [11:0] s, input logic [11:0] d, input logic [7:0] v);
    logic [1:0] fl;
    fl = {flag_n_o, flag_z_o};
    if (s != ACC_ALIAS_ADDR) i_mpl_dmem_model.mem[s] = v;
    issue({COPY_SRC_PFX, s});
    check(second_word_o, 1'b1);
    issue({COPY_DST_PFX, d});
    check(d == ACC_ALIAS_ADDR ? acc_o : i_mpl_dmem_model.mem[d], v);
    check({flag_n_o, flag_z_o}, fl);
  endtask
  // Destinations avoid counter and stack bytes
  task automatic t_full_copy;
    xcopy(12'h123, 12'h0fe, 8'h33);
    xcopy(12'hfff, 12'h000, 8'h01);
    issue(16'h0e77);
    xcopy(ACC_ALIAS_ADDR, 12'h456, 8'h77);
    xcopy(12'h789, ACC_ALIAS_ADDR, 8'hc4);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    resetn_i = 1'b0;
    instr_i = 16'h0000;
    ext_set_en_i = 1'b0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1;
    check({acc_o, bank_selector_o, data_pointer_pair_o}, 52'h0);
    check({phase_o, dmem_rd_o, dmem_wr_o, flag_n_o, flag_z_o}, 6'h00);
    t_literals();
    t_pointers();
    t_file_copy();
    t_full_copy();
    give_verdict();
  end
endmodule // move_and_pointer_load_ops_test
bind mpl_move_exec mpl_exec_properties i_mpl_exec_properties (.mclk_i, .resetn_i, .instr_i,
  .phase_o, .dmem_addr_o, .dmem_rd_o, .dmem_wr_o, .dmem_wdata_o, .dmem_rdata_i, .acc_o,
  .bank_selector_o, .flag_n_o, .flag_z_o);
`default_nettype wire

/* File: mpl_addr_former.sv */
`timescale 1ns/1ps
`default_nettype none

module mpl_addr_former
  import mpl_pkg::*;
(
  // Operand
  input  wire logic [DATA_W-1:0] fadr_i,
  input  wire logic              bank_bit_i,
  // Context
  input  wire logic [DATA_W-1:0] bank_sel_i,
  input  wire logic              ext_set_en_i,
  input  wire logic [ADDR_W-1:0] index_ptr_i,
  // Result
  output logic      [ADDR_W-1:0] addr_o
);

  logic [ADDR_W-1:0] offset_addr;

  assign offset_addr = index_ptr_i + {{(ADDR_W-DATA_W){1'b0}}, fadr_i};

  always_comb begin
    if (bank_bit_i) begin
      addr_o = {bank_sel_i[NIB_W-1:0], fadr_i}; // RQ6
    end else if (ext_set_en_i && (fadr_i < ACCESS_SPLIT)) begin
      addr_o = offset_addr; // RQ7
    end else if (fadr_i < ACCESS_SPLIT) begin
      addr_o = {ACCESS_LO_BANK, fadr_i}; // RQ6
    end else begin
      addr_o = {ACCESS_HI_BANK, fadr_i}; // RQ5
    end
  end

endmodule // mpl_addr_former

`default_nettype wire

/* File: mpl_dmem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mpl_dmem_model
  import mpl_pkg::*;
(
  // Bus from the core
  input  wire logic              mclk_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Read data
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [0:4095];
  // Write at the edge ending phase 3
  always @(posedge mclk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
  // Idle bus shows the inverse, never stale data
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule // mpl_dmem_model
`default_nettype wire

/* File: mpl_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mpl_exec_properties
  import mpl_pkg::*;
(
  // Clock and reset
  input wire logic              mclk_i,
  input wire logic              resetn_i,
  // Fetch and memory
  input wire logic [WORD_W-1:0] instr_i,
  input wire logic [1:0]        phase_o,
  input wire logic [ADDR_W-1:0] dmem_addr_o,
  input wire logic              dmem_rd_o,
  input wire logic              dmem_wr_o,
  input wire logic [DATA_W-1:0] dmem_wdata_o,
  input wire logic [DATA_W-1:0] dmem_rdata_i,
  // Core state
  input wire logic [DATA_W-1:0] acc_o,
  input wire logic [DATA_W-1:0] bank_selector_o,
  input wire logic              flag_n_o,
  input wire logic              flag_z_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic take;
  assign take = phase_o == 2'h0;
  //////////////////////////////////////////////////////////////////////
  chk_phase_order:
  assert property (take |=> phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3 ##1 take)
    else $error("phase order broken");
  chk_read_phase:
  assert property (dmem_rd_o |-> phase_o == 2'h1) else $error("read outside phase 1");
  chk_write_phase:
  assert property (dmem_wr_o |-> phase_o == 2'h3) else $error("write outside phase 3");
  chk_bank_upper:
  assert property (bank_selector_o[7:4] == 4'h0) else $error("selector upper bits set");
  chk_acc_literal:
  assert property (take && instr_i[15:8] == ACC_LIT_PFX |-> ##4
    acc_o == $past(instr_i[7:0], 4) && flag_z_o == $past(flag_z_o, 4))
    else $error("accumulator literal wrong");
  chk_bank_literal:
  assert property (take && instr_i[15:8] == BANK_LIT_PFX |-> ##4
    bank_selector_o == {4'h0, $past(instr_i[3:0], 4)}) else $error("bank literal wrong");
  chk_copy_to_acc:
  assert property (take && instr_i[15:10] == FILE_COPY_PFX && !instr_i[9] |-> ##1 dmem_rd_o
    ##3 acc_o == $past(dmem_rdata_i, 3) && flag_z_o == (acc_o == 8'h00) && flag_n_o == acc_o[7])
    else $error("file copy to accumulator wrong");
  chk_copy_back:
  assert property (take && instr_i[15:10] == FILE_COPY_PFX && instr_i[9] |-> ##1 dmem_rd_o
    ##2 dmem_wr_o && dmem_wdata_o == $past(dmem_rdata_i, 2) && dmem_addr_o == $past(dmem_addr_o, 2))
    else $error("file copy write back wrong");
  chk_full_copy:
  assert property (take && instr_i[15:12] == COPY_SRC_PFX |-> ##1 (!dmem_wr_o)[*4]
    ##1 (!dmem_rd_o)[*3] ##1 flag_z_o == $past(flag_z_o, 8) && flag_n_o == $past(flag_n_o, 8))
    else $error("full copy sequence wrong");
  cover property (take && instr_i[15:12] == COPY_SRC_PFX);
  cover property (take && instr_i[15:PTR_PFX_LSB] == PTR_LOAD_PFX);
  cover property (dmem_wr_o);
endmodule // mpl_exec_properties
`default_nettype wire

/* File: mpl_move_exec.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1 - Pointer literal load puts 12-bit constant into pointer pair 0..2, flags untouched.
// RQ2 - Pointer load is two words, two cycles: high part first, low byte second.
// RQ3 - File copy 0101 00da f copies register in one cycle, updating N and Z only.
// RQ4 - File copy destination bit 0 writes accumulator, 1 writes the register back.
// RQ5 - Byte instruction address reaches any location of a 256-byte bank.
// RQ6 - Bank bit 0 selects access bank; bank bit 1 uses the bank selector.
// RQ7 - Bank bit 0, extended set on, address up to 95: indexed literal offset.
// RQ8 - Full copy: words 1100 source, 1111 destination; two cycles, no flags.
// RQ9 - Full copy reaches whole 4096-byte space directly, no bank selection.
// RQ10 - Full copy accepts the accumulator as source or destination.
// RQ11 - Software never targets counter low byte or stack top bytes with full copy.
// RQ12 - Full copy reads source in cycle one; writes destination in last phase.
// RQ13 - Bank literal 0000 0001 k loads selector low nibble, upper nibble forced zero.
// RQ14 - Accumulator literal 0000 1110 k loads accumulator in one cycle, no flags.
// RQ15 - One-cycle instructions: decode, read, process, write phases in order.

module mpl_move_exec
  import mpl_pkg::*;
(
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  // Program memory fetch
  input  wire logic [WORD_W-1:0]         instr_i,
  output logic      [1:0]                phase_o,
  output logic                           second_word_o,
  // Mode
  input  wire logic                      ext_set_en_i,
  // Banked data memory
  output logic      [ADDR_W-1:0]         dmem_addr_o,
  output logic                           dmem_rd_o,
  output logic                           dmem_wr_o,
  output logic      [DATA_W-1:0]         dmem_wdata_o,
  input  wire logic [DATA_W-1:0]         dmem_rdata_i,
  // Core state
  output logic      [DATA_W-1:0]         acc_o,
  output logic      [DATA_W-1:0]         bank_selector_o,
  output logic      [NUM_PTR*ADDR_W-1:0] data_pointer_pair_o,
  output logic                           flag_n_o,
  output logic                           flag_z_o
);

  mpl_phase_t        phase;
  mpl_state_t        state;
  logic [WORD_W-1:0] ir;
  logic [WORD_W-1:0] ir_held;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] bank_selector;
  logic [ADDR_W-1:0] data_pointer_pair [NUM_PTR];
  logic [1:0]        ptr_sel;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic              flag_n;
  logic              flag_z;

  logic              is_file_copy;
  logic              is_copy_src;
  logic              is_copy_dst;
  logic              is_bank_lit;
  logic              is_acc_lit;
  logic              is_ptr_load;
  logic              is_ptr_low;
  logic [ADDR_W-1:0] banked_addr;
  logic [ADDR_W-1:0] full_addr;
  logic              full_is_acc;
  logic [DATA_W-1:0] lit;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Phase 0 decodes straight from the fetch port
  assign ir           = (phase == PH_DECODE) ? instr_i : ir_held; // RQ15
  assign lit          = ir[DATA_W-1:0];
  assign full_addr    = ir[ADDR_W-1:0]; // RQ9
  assign full_is_acc  = (full_addr == ACC_ALIAS_ADDR); // RQ10
  assign is_file_copy = (state == ST_FIRST) &&
                        (ir[WORD_W-1:FC_PFX_LSB] == FILE_COPY_PFX); // RQ3
  assign is_copy_src  = (state == ST_FIRST) &&
                        (ir[WORD_W-1:NIB_HI_LSB] == COPY_SRC_PFX); // RQ8
  assign is_copy_dst  = (state == ST_COPY_DEST) &&
                        (ir[WORD_W-1:NIB_HI_LSB] == COPY_DST_PFX); // RQ8
  assign is_bank_lit  = (state == ST_FIRST) &&
                        (ir[WORD_W-1:LIT_PFX_LSB] == BANK_LIT_PFX); // RQ13
  assign is_acc_lit   = (state == ST_FIRST) &&
                        (ir[WORD_W-1:LIT_PFX_LSB] == ACC_LIT_PFX); // RQ14
  assign is_ptr_load  = (state == ST_FIRST) &&
                        (ir[WORD_W-1:PTR_PFX_LSB] == PTR_LOAD_PFX) &&
                        (ir[PTR_SEL_LSB+1:PTR_SEL_LSB] <= PTR_SEL_MAX); // RQ1
  assign is_ptr_low   = (state == ST_PTR_LOW) &&
                        (ir[WORD_W-1:NIB_HI_LSB] == COPY_DST_PFX); // RQ2

  mpl_addr_former u_addr_former (
    .fadr_i       (ir[DATA_W-1:0]),
    .bank_bit_i   (ir[FC_BANK_BIT]),
    .bank_sel_i   (bank_selector),
    .ext_set_en_i (ext_set_en_i),
    .index_ptr_i  (data_pointer_pair[PTR_IDX_SEL]),
    .addr_o       (banked_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      phase <= PH_DECODE;
    end else begin
      case (phase)
        PH_DECODE:  phase <= PH_READ; // RQ15
        PH_READ:    phase <= PH_PROCESS;
        PH_PROCESS: phase <= PH_WRITE;
        PH_WRITE:   phase <= PH_DECODE;
        default:    phase <= PH_DECODE;
      endcase
    end
  end

  // Instruction word latch at decode
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ir_held <= '0;
    end else if (phase == PH_DECODE) begin
      ir_held <= instr_i;
    end
  end

  // Second word tracking
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state <= ST_FIRST;
    end else if (phase == PH_WRITE) begin
      if (is_ptr_load) begin
        state <= ST_PTR_LOW; // RQ2
      end else if (is_copy_src) begin
        state <= ST_COPY_DEST; // RQ8
      end else begin
        state <= ST_FIRST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory port

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dmem_addr_o  <= '0;
      dmem_rd_o    <= 1'b0;
      dmem_wr_o    <= 1'b0;
      dmem_wdata_o <= '0;
    end else begin
      dmem_rd_o <= 1'b0;
      dmem_wr_o <= 1'b0;
      case (phase)
        PH_DECODE: begin
          if (is_file_copy) begin
            dmem_addr_o <= banked_addr; // RQ5
            dmem_rd_o   <= 1'b1; // RQ15
          end else if (is_copy_src && !full_is_acc) begin
            dmem_addr_o <= full_addr; // RQ12
            dmem_rd_o   <= 1'b1; // RQ12
          end
        end
        PH_PROCESS: begin
          if (is_file_copy && ir[FC_DEST_BIT]) begin
            dmem_addr_o  <= banked_addr; // RQ4
            dmem_wr_o    <= 1'b1;
            dmem_wdata_o <= result;
          end else if (is_copy_dst && !full_is_acc) begin
            dmem_addr_o  <= full_addr; // RQ9
            dmem_wr_o    <= 1'b1; // RQ12
            dmem_wdata_o <= operand;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Operand capture during read phase
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      operand <= '0;
    end else if (phase == PH_READ) begin
      if (is_copy_src && full_is_acc) begin
        operand <= acc; // RQ10
      end else if (is_file_copy || is_copy_src) begin
        operand <= dmem_rdata_i;
      end
    end
  end

  always_comb begin
    result = operand;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      acc <= ACC_RESET;
    end else if (phase == PH_WRITE) begin
      if (is_file_copy && !ir[FC_DEST_BIT]) begin
        acc <= result; // RQ4
      end else if (is_acc_lit) begin
        acc <= lit; // RQ14
      end else if (is_copy_dst && full_is_acc) begin
        acc <= operand; // RQ10
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end else if ((phase == PH_WRITE) && is_file_copy) begin
      flag_n <= result[DATA_W-1]; // RQ3
      flag_z <= (result == '0); // RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank selector

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bank_selector <= BANK_RESET;
    end else if ((phase == PH_WRITE) && is_bank_lit) begin
      bank_selector <= {{(DATA_W-NIB_W){1'b0}}, lit[NIB_W-1:0]}; // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pointer pairs

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ptr_sel <= '0;
    end else if ((phase == PH_WRITE) && is_ptr_load) begin
      ptr_sel <= ir[PTR_SEL_LSB+1:PTR_SEL_LSB];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          data_pointer_pair[gi] <= PTR_RESET;
        end else if (phase == PH_WRITE) begin
          if (is_ptr_load && (ir[PTR_SEL_LSB+1:PTR_SEL_LSB] == 2'(gi))) begin
            data_pointer_pair[gi][ADDR_W-1:DATA_W] <= ir[NIB_W-1:0]; // RQ2
          end else if (is_ptr_low && (ptr_sel == 2'(gi))) begin
            data_pointer_pair[gi][DATA_W-1:0] <= lit; // RQ1
          end
        end
      end
      assign data_pointer_pair_o[gi*ADDR_W +: ADDR_W] = data_pointer_pair[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign phase_o         = phase;
  assign second_word_o   = (state != ST_FIRST);
  assign acc_o           = acc;
  assign bank_selector_o = bank_selector;
  assign flag_n_o        = flag_n;
  assign flag_z_o        = flag_z;

endmodule // mpl_move_exec

`default_nettype wire

/* File: mpl_pkg.sv */
package mpl_pkg;

  // Phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } mpl_phase_t;

  // Which word of a two-word instruction is pending
  typedef enum logic [1:0] {
    ST_FIRST     = 2'b00,
    ST_PTR_LOW   = 2'b01,
    ST_COPY_DEST = 2'b10
  } mpl_state_t;

  // Widths
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned NUM_PTR = 3;

  // File copy: 0101 00da ffff ffff
  localparam logic [5:0]  FILE_COPY_PFX  = 6'h14;
  localparam int unsigned FC_PFX_LSB     = 10;
  localparam int unsigned FC_DEST_BIT    = 9;
  localparam int unsigned FC_BANK_BIT    = 8;

  // Full space copy: 1100 source, 1111 destination
  localparam logic [3:0]  COPY_SRC_PFX   = 4'hc;
  localparam logic [3:0]  COPY_DST_PFX   = 4'hf;
  localparam int unsigned NIB_HI_LSB     = 12;

  // Byte literal ops: 0000 0001 k, 0000 1110 k
  localparam logic [7:0]  BANK_LIT_PFX   = 8'h01;
  localparam logic [7:0]  ACC_LIT_PFX    = 8'h0e;
  localparam int unsigned LIT_PFX_LSB    = 8;

  // Pointer literal load: 1110 1110 00pp kkkk, then 1111 0000 kkkk kkkk
  localparam logic [9:0]  PTR_LOAD_PFX   = 10'h3b8;
  localparam int unsigned PTR_PFX_LSB    = 6;
  localparam int unsigned PTR_SEL_LSB    = 4;
  localparam logic [1:0]  PTR_SEL_MAX    = 2'h2;
  localparam logic [1:0]  PTR_IDX_SEL    = 2'h2;

  // Data space layout
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [ADDR_W-1:0] ACC_ALIAS_ADDR = 12'hff0;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] BANK_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET  = 12'h000;

endpackage : mpl_pkg
